/* acm_chmap.v */
/*
 Channel map registers for four channels behind an APB slave, plus
 input routing and setup selection for the channel being converted.
 Assumes APB3 master on pclk, asynchronous active-low presetn.
*/
`default_nettype none
`include "acm_regs.vh"

module acm_chmap #(
  parameter NCH = 4,
  parameter [15:0] DWELL = `ACM_DWELL_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Converter steering
  output reg [4:0] pos_input_ff,
  output reg [4:0] neg_input_ff,
  output reg [1:0] setup_sel_ff,
  output wire [1:0] active_channel,
  output wire converting,
  output wire conv_done
);

  reg [15:0] chmap_ff [0:NCH-1];
  reg run_ff;
  wire [NCH-1:0] enables;
  wire [4:0] idx;
  wire wr_en;
  wire in_map;
  wire [1:0] ch_word;
  wire [15:0] act_map;
  genvar g;

  ///////////////////////////////////////////////////////////////////////
  // Address decode
  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = (a[31:7] == 25'h0) && (a[1:0] == 2'h0) &&
        ((a[6:2] >= `ACM_CHMAP_IDX0 && a[6:2] <= `ACM_CHMAP_IDX3) ||
         a[6:2] == `ACM_SEQ_CTRL_IDX || a[6:2] == `ACM_SEQ_STAT_IDX);
    end
  endfunction

  assign idx = paddr[6:2];
  assign in_map = (idx >= `ACM_CHMAP_IDX0) && (idx <= `ACM_CHMAP_IDX3) &&
    (paddr[31:7] == 25'h0) && (paddr[1:0] == 2'h0);
  assign ch_word = idx[1:0];
  assign pready = 1'b1;
  // Zero-wait slave; unmapped access is flagged, not stored
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign wr_en = psel && penable && pwrite && is_mapped(paddr);

  ///////////////////////////////////////////////////////////////////////
  // Channel map registers
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_map
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // Channel 0 starts enabled so a fresh part converts something
          chmap_ff[g] <= (g == 0) ? `ACM_CHMAP0_RST : `ACM_CHMAP_RST;
        end else if (wr_en && in_map && ch_word == g) begin
          // Bit 14 and bits 11:10 never store
          chmap_ff[g] <= pwdata[15:0] & `ACM_CHMAP_WMASK;
        end
      end
      assign enables[g] = chmap_ff[g][`ACM_EN_BIT];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      run_ff <= 1'b1;
    else if (wr_en && idx == `ACM_SEQ_CTRL_IDX)
      run_ff <= pwdata[0];
  end

  ///////////////////////////////////////////////////////////////////////
  // Read data
  always @* begin
    prdata = 32'h0;
    if (psel && !pwrite && in_map) begin
      prdata = {16'h0, chmap_ff[ch_word]};
    end else if (psel && !pwrite && is_mapped(paddr)) begin
      if (idx == `ACM_SEQ_CTRL_IDX)
        prdata = {31'h0, run_ff};
      else
        prdata = {27'h0, enables == {NCH{1'b0}}, converting, 1'b0, active_channel};
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Sequencer
  acm_seq #(
    .NCH(NCH),
    .DWELL(DWELL)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_ff),
    .enables(enables),
    .active_ch_ff(active_channel),
    .converting_ff(converting),
    .conv_done_ff(conv_done)
  );

  ///////////////////////////////////////////////////////////////////////
  // Routing of the active channel's map to the modulator
  assign act_map = chmap_ff[active_channel];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_input_ff <= `ACM_IN_ZERO;
      neg_input_ff <= `ACM_IN_ONE;
      setup_sel_ff <= 2'h0;
    end else if (converting) begin
      pos_input_ff <= act_map[`ACM_POS_HI:`ACM_POS_LO];
      neg_input_ff <= act_map[`ACM_NEG_HI:`ACM_NEG_LO];
      // Each channel indexes its own setup group; sharing is allowed
      setup_sel_ff <= act_map[`ACM_SETUP_HI:`ACM_SETUP_LO];
    end
  end

endmodule // acm_chmap
`default_nettype wire

/* acm_chmap_sva.sv */
/*
 Port checker for acm_chmap.
 Assumes a bind onto acm_chmap, one clock.
*/
`default_nettype none
module acm_sva (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Sequencer
  input wire [1:0] active_channel,
  input wire converting,
  input wire conv_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rdq = acc && !pwrite;
  // Dwell of 8 leaves 7 quiet cycles
  sequence quiet_s; !conv_done [*7]; endsequence
  zero_wait_a: assert property (acc |-> pready) else $error("wait");
  hole_err_a: assert property (acc && paddr == 32'h7c |-> pslverr) else $error("hole");
  map_ok_a: assert property (acc && paddr == 32'h4c |-> !pslverr) else $error("err");
  idle_err_a: assert property (!acc |-> !pslverr) else $error("stray");
  rsv_zero_a: assert property (rdq && paddr[31:4] == 28'h4 |->
    (prdata & 32'hffff4c00) == 0) else $error("rsv");
  done_gap_a: assert property (conv_done |=> quiet_s) else $error("gap");
  done_busy_a: assert property (conv_done |-> converting) else $error("busy");
  stat_read_a: assert property (rdq && paddr == 32'h64 |->
    {prdata[3], prdata[1:0]} == {converting, active_channel}) else $error("stat");
endmodule // acm_sva
bind acm_chmap acm_sva u_acm_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .prdata, .pslverr, .active_channel, .converting, .conv_done);
`default_nettype wire

/* acm_regs.vh */
/*
 Constants for the channel map configuration block: register offsets,
 field positions, reset values, input codes and sequencer timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ACM_REGS_VH
`define ACM_REGS_VH

// Word indices (byte address is index times four, so index 0x13 is byte 0x4c)
`define ACM_CHMAP_IDX0 5'h10
`define ACM_CHMAP_IDX1 5'h11
`define ACM_CHMAP_IDX2 5'h12
`define ACM_CHMAP_IDX3 5'h13
`define ACM_SEQ_CTRL_IDX 5'h18
`define ACM_SEQ_STAT_IDX 5'h19

// Channel map fields
`define ACM_EN_BIT 15
`define ACM_RSV14_BIT 14
`define ACM_SETUP_HI 13
`define ACM_SETUP_LO 12
`define ACM_POS_HI 9
`define ACM_POS_LO 5
`define ACM_NEG_HI 4
`define ACM_NEG_LO 0
`define ACM_CHMAP_WMASK 16'hb3ff
`define ACM_CHMAP0_RST 16'h8001
`define ACM_CHMAP_RST 16'h0001

// Input codes
`define ACM_IN_ZERO 5'h00
`define ACM_IN_ONE 5'h01
`define ACM_IN_FOUR 5'h04
`define ACM_IN_REFP 5'h15
`define ACM_IN_REFN 5'h16

// Dwell per channel in cycles (40 MHz)
`define ACM_DWELL_CYC 16'h0008

`endif

/* acm_seq.v */
/*
 Round-robin sequencer over the enabled channels.
 Assumes one clock pclk and asynchronous active-low presetn.
*/
`default_nettype none
`include "acm_regs.vh"

module acm_seq #(
  parameter NCH = 4,
  parameter [15:0] DWELL = `ACM_DWELL_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire run,
  input wire [NCH-1:0] enables,
  // Status
  output reg [1:0] active_ch_ff,
  output reg converting_ff,
  output reg conv_done_ff
);

  reg [15:0] cnt_ff;
  reg [1:0] nxt_ch;
  integer i;
  reg found;
  reg [31:0] cand;

  ///////////////////////////////////////////////////////////////////////
  // Next enabled channel after the current one
  always @* begin
    nxt_ch = active_ch_ff;
    found = 1'b0;
    cand = 32'h0;
    for (i = 1; i <= NCH; i = i + 1) begin
      cand = (active_ch_ff + i) % NCH;
      if (!found && enables[cand]) begin
        // Channel index is two bits wide
        nxt_ch = cand[1:0];
        found = 1'b1;
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ch_ff <= 2'h0;
      converting_ff <= 1'b0;
      conv_done_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      conv_done_ff <= 1'b0;
      if (!run || enables == {NCH{1'b0}}) begin
        converting_ff <= 1'b0;
        cnt_ff <= 16'h0000;
      end else if (!converting_ff || !enables[active_ch_ff]) begin
        // Start, or drop a channel disabled mid-dwell
        converting_ff <= 1'b1;
        cnt_ff <= 16'h0000;
        if (!enables[active_ch_ff])
          active_ch_ff <= nxt_ch;
      end else if (cnt_ff == DWELL - 16'h0001) begin
        conv_done_ff <= 1'b1;
        cnt_ff <= 16'h0000;
        active_ch_ff <= nxt_ch;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

endmodule // acm_seq
`default_nettype wire

/* adc_channel_map_config_test.sv */
/*
 Bench for acm_chmap: maps, holes, steering, sequencing.
 Assumes the checker binds itself.
*/
`default_nettype none
module adc_channel_map_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [31:0] paddr = 0, pwdata = 0, rd, v, p, seed = 32'hb280b16b;
  logic [4:0] c;
  logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h04, 5'h15, 5'h16};
  wire pready, pslverr, converting, conv_done;
  wire [31:0] prdata;
  wire [4:0] pos_input_ff, neg_input_ff;
  wire [1:0] setup_sel_ff, active_channel;
  int fails = 0, n_checks = 0;
  acm_chmap u_acm_chmap (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .pos_input_ff, .neg_input_ff, .setup_sel_ff,
    .active_channel, .converting, .conv_done);
  initial forever #12.5 pclk = ~pclk;
  initial begin
    #200us;
    fails++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input logic [31:0] seen, want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(0, 32'h40 + 4 * i, 0);
      check(rd, i ? 32'h1 : 32'h8001);
    end
    apb(0, 32'h7c, 0);
    check(rd, 0);
    check(err, 1);
    repeat (24) begin
      v = rnd() & 32'hffffbfff;
      p = v[16] ? 32'h4c : 32'h48;
      apb(1, p, v);
      apb(0, p, 0);
      check(rd, v & 32'hb3ff);
    end
    $display("register test done");
    apb(1, 32'h40, 0);
    apb(1, 32'h4c, 0);
    foreach (codes[k]) begin
      c = codes[k];
      apb(1, 32'h48, {16'h0, 2'b10, c[1:0], 2'b0, c, c});
      for (int i = 0; i < 99 && active_channel !== 2; i++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      check({neg_input_ff, pos_input_ff, setup_sel_ff}, {c, c, c[1:0]});
    end
    // Channel three joins on setup three
    apb(1, 32'h4c, 32'hb000);
    // Sample between pulses so the channel is settled
    @(negedge pclk);
    while (conv_done) @(negedge pclk);
    p = active_channel;
    repeat (4) begin
      for (int i = 0; i < 99 && conv_done !== 1; i++) @(negedge pclk);
      repeat (2) @(negedge pclk);
      v = active_channel;
      check(v ^ p, 1);
      p = v;
    end
    @(posedge pclk);
    apb(1, 32'h60, 0);
    repeat (20) @(posedge pclk);
    check(converting, 0);
    $display("sequencer test done");
    print_verdict();
  end
endmodule // adc_channel_map_config_test
`default_nettype wire
